// ==== hw/fdc_status_format.sv ====
`timescale 1ns/100ps
`include "fdc_regs.svh"
module fdc_status_format (
    input wire logic mclk, // 100 MHz clock
    input wire logic rst, // Synchronous reset, high
    input wire logic master_reset_n, // Device reset pin, low
    input wire logic cs_n, // Chip select, low
    input wire logic rd_strobe, // Register read strobe
    input wire logic wr_strobe, // Register write strobe
    input wire logic [1:0] reg_addr, // Register select
    input wire logic [7:0] data_in, // Host write data
    output logic [7:0] data_out, // Host read data
    input wire logic ready_in, // Drive ready, high
    input wire logic write_protect_in, // Write protect, low active
    input wire logic head_load_timing_in, // Head settled, high
    input wire logic track_zero_in, // Track zero, low active
    input wire logic index_pulse_in, // Index, low active
    input wire logic density_select_n, // Low selects MFM
    input wire logic seek_error_in, // Verify failure event
    input wire logic id_crc_error_in, // ID field CRC event
    input wire logic data_crc_error_in, // Data field CRC event
    input wire logic record_not_found, // Record search failed event
    input wire logic deleted_mark_in, // Deleted data mark seen
    input wire logic write_fault_in, // Drive write fault event
    input wire logic disk_byte_req, // Shifter wants next byte
    output logic [7:0] disk_byte, // Byte for serializer
    output logic disk_byte_valid, // Byte strobe, one cycle
    output logic missing_clock, // Byte carries a missing clock
    output logic write_gate, // Writing on the disk
    output logic head_load_out, // Head load
    output logic data_request, // Data register wants service
    output logic interrupt_request // Command done
);
    logic [1:0] sy_rdy, sy_wp, sy_tz, sy_ip, sy_den, sy_mr, sy_hlt;
    logic rdy_s, wp_s, tz_s, ip_s, mfm_s, mr_s, hlt_s;
    fdc_pkg::cmd_type_t ctype_ff, nxt_ctype;
    fdc_pkg::fmt_state_t st_ff, nxt_st;
    logic busy_ff, nxt_busy;
    logic [5:2] err_ff, nxt_err;
    logic drq_ff, nxt_drq;
    logic interrupt_request_ff, nxt_interrupt_request;
    logic hld_ff, nxt_hld;
    logic ip_d_ff, nxt_ip_d;
    logic [`CNT_W-1:0] tmr_ff, nxt_tmr;
    logic [7:0] dout_ff, nxt_dout;
    logic [7:0] byte_ff, nxt_byte;
    logic bval_ff, nxt_bval;
    logic mc_ff, nxt_mc;
    logic wg_ff, nxt_wg;
    logic [7:0] status;
    logic ip_edge, host_wr_data, host_wr_cmd, host_rd_status, host_rd_data;
    logic crc_preset, crc_feed;
    logic [15:0] crc_val;
    logic fifo_flush;
    byte_stream_if host_bs();
    byte_stream_if disk_bs();

    // Two-stage synchronisers for the drive, density and reset pins; only stage two is read
    always_ff @(posedge mclk) begin
        if (rst) begin
            sy_rdy <= 2'h0;
            sy_wp <= 2'h3;
            sy_tz <= 2'h3;
            sy_ip <= 2'h3;
            sy_den <= 2'h3;
            sy_mr <= 2'h0;
            sy_hlt <= 2'h0;
        end else begin
            sy_rdy <= {sy_rdy[0], ready_in};
            sy_wp <= {sy_wp[0], write_protect_in};
            sy_tz <= {sy_tz[0], track_zero_in};
            sy_ip <= {sy_ip[0], index_pulse_in};
            sy_den <= {sy_den[0], density_select_n};
            sy_mr <= {sy_mr[0], master_reset_n};
            sy_hlt <= {sy_hlt[0], head_load_timing_in};
        end
    end
    assign rdy_s = sy_rdy[1];
    assign wp_s = sy_wp[1];
    assign tz_s = sy_tz[1];
    assign ip_s = sy_ip[1];
    assign mfm_s = ~sy_den[1];
    assign mr_s = ~sy_mr[1];
    assign hlt_s = sy_hlt[1];

    // Host strobes decoded once
    assign host_wr_data = !cs_n && wr_strobe && reg_addr == `ADDR_DATA;
    assign host_wr_cmd = !cs_n && wr_strobe && reg_addr == `ADDR_STATUS;
    assign host_rd_status = !cs_n && rd_strobe && reg_addr == `ADDR_STATUS;
    assign host_rd_data = !cs_n && rd_strobe && reg_addr == `ADDR_DATA;
    assign ip_edge = ip_d_ff && !ip_s; // Falling index edge

    // Command nibble to type
    function automatic fdc_pkg::cmd_type_t decode_cmd(input logic [3:0] n);
        case (n)
            `CMD_READ_ADDR: decode_cmd = fdc_pkg::CT_RADDR;
            `CMD_READ_SEC_A, `CMD_READ_SEC_B: decode_cmd = fdc_pkg::CT_RSEC;
            `CMD_WRITE_SEC_A, `CMD_WRITE_SEC_B: decode_cmd = fdc_pkg::CT_WSEC;
            `CMD_READ_TRK: decode_cmd = fdc_pkg::CT_RTRK;
            `CMD_WRITE_TRK: decode_cmd = fdc_pkg::CT_WTRK;
            default: decode_cmd = fdc_pkg::CT_POS;
        endcase
    endfunction

    // Format bytes are buffered; FIFO ready stalls the host request
    byte_fifo #(.WIDTH(8), .DEPTH(`FIFO_DEPTH)) u_fifo (
        .mclk(mclk),
        .rst(rst),
        .flush(fifo_flush),
        .wr(host_bs.snk),
        .rd(disk_bs.src)
    );
    assign host_bs.data = data_in;
    assign host_bs.valid = host_wr_data && ctype_ff == fdc_pkg::CT_WTRK && busy_ff;
    assign fifo_flush = !busy_ff;
    assign disk_bs.ready = (st_ff == fdc_pkg::S_RUN) && disk_byte_req;

    crc_ccitt u_crc (
        .mclk(mclk),
        .rst(rst),
        .preset(crc_preset),
        .feed(crc_feed),
        .din(nxt_byte),
        .crc(crc_val)
    );

    // Status composition by command type; unused bits read zero
    always_comb begin
        status = 8'h00;
        status[`ST_NOT_READY] = !rdy_s || mr_s;
        status[`ST_BUSY] = busy_ff;
        case (ctype_ff)
            fdc_pkg::CT_POS: begin
                status[`ST_PROTECT] = !wp_s;
                status[`ST_HEAD_REC] = hld_ff && hlt_s;
                status[`ST_SEEK_MISS] = err_ff[4];
                status[`ST_CRC] = err_ff[3];
                status[`ST_TRK_LOST] = !tz_s;
                status[`ST_IDX_REQ] = !ip_s;
            end
            fdc_pkg::CT_RADDR, fdc_pkg::CT_RSEC, fdc_pkg::CT_WSEC: begin
                status[`ST_PROTECT] = ctype_ff == fdc_pkg::CT_WSEC && !wp_s;
                status[`ST_HEAD_REC] = ctype_ff != fdc_pkg::CT_RADDR && err_ff[5];
                status[`ST_SEEK_MISS] = err_ff[4];
                status[`ST_CRC] = err_ff[3];
                status[`ST_TRK_LOST] = err_ff[2];
                status[`ST_IDX_REQ] = drq_ff;
            end
            fdc_pkg::CT_RTRK, fdc_pkg::CT_WTRK: begin
                status[`ST_PROTECT] = ctype_ff == fdc_pkg::CT_WTRK && !wp_s;
                status[`ST_HEAD_REC] = ctype_ff == fdc_pkg::CT_WTRK && err_ff[5];
                status[`ST_TRK_LOST] = err_ff[2];
                status[`ST_IDX_REQ] = drq_ff;
            end
            default: status = 8'h00;
        endcase
    end

    // Command, error, request and write-track sequencing
    always_comb begin
        nxt_ctype = ctype_ff;
        nxt_st = st_ff;
        nxt_busy = busy_ff;
        nxt_err = err_ff;
        nxt_drq = drq_ff;
        nxt_interrupt_request = interrupt_request_ff;
        nxt_hld = hld_ff;
        nxt_ip_d = ip_s;
        nxt_tmr = tmr_ff;
        nxt_byte = byte_ff;
        nxt_bval = 1'b0;
        nxt_mc = mc_ff;
        nxt_wg = wg_ff;
        crc_preset = 1'b0;
        crc_feed = 1'b0;
        if (host_rd_status || host_wr_cmd) begin
            nxt_interrupt_request = 1'b0;
        end
        if (host_wr_data || host_rd_data) begin
            nxt_drq = 1'b0;
        end
        // Hardware-reported errors; the set wins over any clear above
        if (busy_ff) begin
            if (ctype_ff == fdc_pkg::CT_POS) begin
                nxt_err[4] = err_ff[4] | seek_error_in;
                nxt_err[3] = err_ff[3] | id_crc_error_in;
            end else if (ctype_ff != fdc_pkg::CT_RTRK && ctype_ff != fdc_pkg::CT_WTRK) begin
                nxt_err[4] = err_ff[4] | record_not_found;
                nxt_err[3] = err_ff[3] | id_crc_error_in | data_crc_error_in;
            end
            if (ctype_ff == fdc_pkg::CT_RSEC) begin
                nxt_err[5] = err_ff[5] | deleted_mark_in;
            end else if (ctype_ff == fdc_pkg::CT_WSEC || ctype_ff == fdc_pkg::CT_WTRK) begin
                nxt_err[5] = err_ff[5] | write_fault_in;
            end
        end
        // Data request service timer: one byte time, doubled in FM
        if (busy_ff && drq_ff && ctype_ff != fdc_pkg::CT_POS && !(host_wr_data || host_rd_data)) begin
            if (tmr_ff == '0) begin
                nxt_err[2] = 1'b1;
                nxt_tmr = mfm_s ? `CNT_W'(`BYTE_CYCLES) : `CNT_W'(2 * `BYTE_CYCLES);
            end else begin
                nxt_tmr = tmr_ff - 1'b1;
            end
        end else begin
            nxt_tmr = mfm_s ? `CNT_W'(`BYTE_CYCLES) : `CNT_W'(2 * `BYTE_CYCLES);
        end
        // Write track: request while the buffer has room
        if (ctype_ff == fdc_pkg::CT_WTRK && busy_ff && host_bs.ready && !host_wr_data) begin
            nxt_drq = 1'b1;
        end
        case (st_ff)
            fdc_pkg::S_IDLE: begin
                nxt_wg = 1'b0;
            end
            fdc_pkg::S_WAIT_IDX: begin
                if (ip_edge) begin
                    if (!disk_bs.valid) begin
                        // No first byte by the index: abort with lost data
                        nxt_err[2] = 1'b1;
                        nxt_busy = 1'b0;
                        nxt_interrupt_request = 1'b1;
                        nxt_drq = 1'b0;
                        nxt_st = fdc_pkg::S_IDLE;
                    end else begin
                        nxt_wg = 1'b1;
                        nxt_st = fdc_pkg::S_RUN;
                    end
                end
            end
            fdc_pkg::S_RUN: begin
                if (ip_edge) begin
                    // Next index ends the format; host filler is dropped
                    nxt_busy = 1'b0;
                    nxt_interrupt_request = 1'b1;
                    nxt_drq = 1'b0;
                    nxt_wg = 1'b0;
                    nxt_st = fdc_pkg::S_IDLE;
                end else if (disk_byte_req) begin
                    nxt_bval = 1'b1;
                    nxt_mc = 1'b0;
                    if (!disk_bs.valid) begin
                        nxt_byte = `BYTE_ZERO; // Underrun substitutes zero
                        crc_feed = 1'b1;
                    end else if (disk_bs.data == `CODE_CRC) begin
                        nxt_byte = crc_val[15:8];
                        nxt_st = fdc_pkg::S_CRC2;
                    end else if (mfm_s && disk_bs.data == `CODE_PRESET) begin
                        nxt_byte = `BYTE_A1;
                        nxt_mc = 1'b1;
                        crc_preset = 1'b1;
                    end else if (mfm_s && disk_bs.data == `CODE_SYNC_C2) begin
                        nxt_byte = `BYTE_C2;
                        nxt_mc = 1'b1;
                        crc_feed = 1'b1;
                    end else begin
                        nxt_byte = disk_bs.data;
                        crc_feed = 1'b1;
                    end
                end
            end
            fdc_pkg::S_CRC2: begin
                // Index during the second CRC byte must still end the format
                if (ip_edge) begin
                    nxt_busy = 1'b0;
                    nxt_interrupt_request = 1'b1;
                    nxt_drq = 1'b0;
                    nxt_wg = 1'b0;
                    nxt_st = fdc_pkg::S_IDLE;
                end else if (disk_byte_req) begin
                    nxt_bval = 1'b1;
                    nxt_mc = 1'b0;
                    nxt_byte = crc_val[7:0];
                    nxt_st = fdc_pkg::S_RUN;
                end
            end
            default: nxt_st = fdc_pkg::S_IDLE;
        endcase
        // New command: non-positioning commands refused when not ready, status recomputed
        if (host_wr_cmd && data_in[7:4] != `CMD_FORCE) begin
            nxt_ctype = decode_cmd(data_in[7:4]);
            nxt_err = 4'h0;
            nxt_drq = 1'b0;
            nxt_st = fdc_pkg::S_IDLE;
            if (decode_cmd(data_in[7:4]) != fdc_pkg::CT_POS && !rdy_s) begin
                nxt_busy = 1'b0;
                nxt_interrupt_request = 1'b1;
            end else if (decode_cmd(data_in[7:4]) == fdc_pkg::CT_WTRK && !wp_s) begin
                nxt_busy = 1'b0;
                nxt_interrupt_request = 1'b1;
            end else begin
                nxt_busy = 1'b1;
                nxt_hld = 1'b1;
                if (decode_cmd(data_in[7:4]) == fdc_pkg::CT_WTRK) begin
                    nxt_drq = 1'b1;
                    nxt_st = fdc_pkg::S_WAIT_IDX;
                end
            end
        end else if (host_wr_cmd) begin
            // Force interrupt stops the command; keeps type and error bits if busy, else clears them
            nxt_busy = 1'b0;
            nxt_drq = 1'b0;
            nxt_wg = 1'b0;
            nxt_st = fdc_pkg::S_IDLE;
            if (!busy_ff) begin
                nxt_ctype = fdc_pkg::CT_POS;
                nxt_err = 4'h0;
            end
        end
    end

    // Status or data register onto the read port
    always_comb begin
        nxt_dout = dout_ff;
        if (host_rd_status) begin
            nxt_dout = status;
        end else if (host_rd_data) begin
            nxt_dout = byte_ff;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst || mr_s) begin
            ctype_ff <= fdc_pkg::CT_POS;
            st_ff <= fdc_pkg::S_IDLE;
            busy_ff <= 1'b0;
            err_ff <= 4'h0;
            drq_ff <= 1'b0;
            interrupt_request_ff <= 1'b0;
            hld_ff <= 1'b0;
            ip_d_ff <= 1'b1;
            tmr_ff <= '0;
            dout_ff <= rst ? 8'h00 : nxt_dout; // Status stays readable in master reset
            byte_ff <= 8'h00;
            bval_ff <= 1'b0;
            mc_ff <= 1'b0;
            wg_ff <= 1'b0;
        end else begin
            ctype_ff <= nxt_ctype;
            st_ff <= nxt_st;
            busy_ff <= nxt_busy;
            err_ff <= nxt_err;
            drq_ff <= nxt_drq;
            interrupt_request_ff <= nxt_interrupt_request;
            hld_ff <= nxt_hld;
            ip_d_ff <= nxt_ip_d;
            tmr_ff <= nxt_tmr;
            dout_ff <= nxt_dout;
            byte_ff <= nxt_byte;
            bval_ff <= nxt_bval;
            mc_ff <= nxt_mc;
            wg_ff <= nxt_wg;
        end
    end

    assign data_out = dout_ff;
    assign disk_byte = byte_ff;
    assign disk_byte_valid = bval_ff;
    assign missing_clock = mc_ff;
    assign write_gate = wg_ff;
    assign head_load_out = hld_ff;
    assign data_request = drq_ff;
    assign interrupt_request = interrupt_request_ff;
endmodule

// ==== common/fdc_regs.svh ====
`ifndef FDC_REGS_SVH
`define FDC_REGS_SVH
// Status bit positions
`define ST_NOT_READY 7
`define ST_PROTECT 6
`define ST_HEAD_REC 5
`define ST_SEEK_MISS 4
`define ST_CRC 3
`define ST_TRK_LOST 2
`define ST_IDX_REQ 1
`define ST_BUSY 0
// Register addresses (a1,a0)
`define ADDR_STATUS 2'h0
`define ADDR_DATA 2'h3
// Format codes
`define CODE_CRC 8'hF7
`define CODE_PRESET 8'hF5
`define CODE_SYNC_C2 8'hF6
`define BYTE_A1 8'hA1
`define BYTE_C2 8'hC2
`define BYTE_ZERO 8'h00
`define CRC_PRESET 16'hFFFF
`define CRC_POLY 16'h1021
// Byte time: 32 us in MFM at 100 MHz, doubled in FM
`define BYTE_TIME_NS 32000
`define CLK_PERIOD_NS 10
`define BYTE_CYCLES (`BYTE_TIME_NS / `CLK_PERIOD_NS)
`define CNT_W 14
// Command type encodings in the command byte upper nibble
`define CMD_READ_ADDR 4'hC
`define CMD_READ_SEC_A 4'h8
`define CMD_READ_SEC_B 4'h9
`define CMD_WRITE_SEC_A 4'hA
`define CMD_WRITE_SEC_B 4'hB
`define CMD_READ_TRK 4'hE
`define CMD_WRITE_TRK 4'hF
`define CMD_FORCE 4'hD
`define FIFO_DEPTH 4
`endif

// ==== common/fdc_pkg.sv ====
package fdc_pkg;
    typedef enum logic [2:0] {
        CT_POS = 3'h0,
        CT_RADDR = 3'h1,
        CT_RSEC = 3'h2,
        CT_RTRK = 3'h3,
        CT_WSEC = 3'h4,
        CT_WTRK = 3'h5
    } cmd_type_t;
    typedef enum logic [3:0] {
        S_IDLE = 4'h1,
        S_WAIT_IDX = 4'h2,
        S_RUN = 4'h4,
        S_CRC2 = 4'h8
    } fmt_state_t;
endpackage

// ==== common/byte_stream_if.sv ====
`timescale 1ns/100ps
interface byte_stream_if;
    logic [7:0] data;
    logic valid;
    logic ready;
    modport src(output data, output valid, input ready);
    modport snk(input data, input valid, output ready);
endinterface

// ==== hw/byte_fifo.sv ====
`timescale 1ns/100ps
module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input wire logic mclk, // Clock
    input wire logic rst, // Synchronous reset
    input wire logic flush, // Empty the buffer
    byte_stream_if.snk wr, // Filling side
    byte_stream_if.src rd // Draining side
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [WIDTH-1:0] nxt_mem [DEPTH];
    logic [AW-1:0] wp_ff, rp_ff, nxt_wp, nxt_rp;
    logic [AW:0] cnt_ff, nxt_cnt;
    logic push, pop;

    // Honest full and empty from the occupancy count
    assign wr.ready = (cnt_ff != (AW+1)'(DEPTH));
    assign rd.valid = (cnt_ff != '0);
    assign rd.data = mem_ff[rp_ff];
    assign push = wr.valid && wr.ready;
    assign pop = rd.valid && rd.ready;

    // Pointer and storage update
    always_comb begin
        nxt_mem = mem_ff;
        nxt_wp = wp_ff;
        nxt_rp = rp_ff;
        nxt_cnt = cnt_ff;
        if (flush) begin
            nxt_wp = '0;
            nxt_rp = '0;
            nxt_cnt = '0;
        end else begin
            if (push) begin
                nxt_mem[wp_ff] = wr.data;
                nxt_wp = (wp_ff == AW'(DEPTH-1)) ? '0 : wp_ff + 1'b1;
            end
            if (pop) begin
                nxt_rp = (rp_ff == AW'(DEPTH-1)) ? '0 : rp_ff + 1'b1;
            end
            nxt_cnt = cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            wp_ff <= '0;
            rp_ff <= '0;
            cnt_ff <= '0;
        end else begin
            wp_ff <= nxt_wp;
            rp_ff <= nxt_rp;
            cnt_ff <= nxt_cnt;
        end
        mem_ff <= nxt_mem;
    end
endmodule

// ==== hw/crc_ccitt.sv ====
`timescale 1ns/100ps
`include "fdc_regs.svh"
module crc_ccitt (
    input wire logic mclk, // Clock
    input wire logic rst, // Synchronous reset
    input wire logic preset, // Load all ones
    input wire logic feed, // Shift one byte in
    input wire logic [7:0] din, // Byte to shift
    output logic [15:0] crc // Running remainder
);
    logic [15:0] crc_ff, nxt_crc;

    // Bytewise update, MSB first, over x16+x12+x5+1
    function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] r;
        r = c;
        for (int i = 7; i >= 0; i--) begin
            r = (r[15] ^ d[i]) ? ((r << 1) ^ `CRC_POLY) : (r << 1);
        end
        return r;
    endfunction

    always_comb begin
        nxt_crc = crc_ff;
        if (preset) begin
            nxt_crc = `CRC_PRESET;
        end else if (feed) begin
            nxt_crc = crc_byte(crc_ff, din);
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            crc_ff <= `CRC_PRESET;
        end else begin
            crc_ff <= nxt_crc;
        end
    end

    assign crc = crc_ff;
endmodule

// ==== dv/fdc_status_format_checker.sv ====
`timescale 1ns/100ps
`include "fdc_regs.svh"
module fdc_status_format_checker (
    input wire logic mclk, // Clock
    input wire logic rst, // Reset
    input wire logic cs_n, // Select
    input wire logic rd_strobe, // Read
    input wire logic wr_strobe, // Write
    input wire logic [1:0] reg_addr, // Register
    input wire logic [7:0] data_in, // Host data
    input wire logic [7:0] data_out, // Read data
    input wire logic ready_in, // Ready
    input wire logic write_protect_in, // Protect
    input wire logic disk_byte_req, // Byte ask
    input wire logic [7:0] disk_byte, // Byte out
    input wire logic disk_byte_valid, // Byte strobe
    input wire logic missing_clock, // Mark byte
    input wire logic write_gate, // Writing
    input wire logic head_load_out, // Head
    input wire logic data_request, // Request
    input wire logic interrupt_request // Done
);
    logic [2:0] ok_ff, nxt_ok, bad_ff, nxt_bad;
    // Settled-level counters; they outlast the input synchronisers
    always_comb begin
        nxt_ok = (rst || !(ready_in && write_protect_in)) ? 3'h0 : ok_ff + {2'h0, ok_ff != 3'h7};
        nxt_bad = (rst || ready_in) ? 3'h0 : bad_ff + {2'h0, bad_ff != 3'h7};
    end
    always_ff @(posedge mclk) begin
        ok_ff <= nxt_ok;
        bad_ff <= nxt_bad;
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    // Write-track command and the refusal that must follow when not ready
    sequence s_cmd_wtrk;
        !cs_n && wr_strobe && reg_addr == 2'h0 && data_in == 8'hF0;
    endsequence
    sequence s_refused;
        !data_request && !write_gate ##[0:3] interrupt_request;
    endsequence
    a_wtrk_accept: assert property (ok_ff == 3'h7 ##0 s_cmd_wtrk |=> data_request && head_load_out)
        else $error("write track not started");
    a_wtrk_refuse: assert property (bad_ff == 3'h7 ##0 s_cmd_wtrk |=> s_refused)
        else $error("write track not refused");
    a_not_ready_bit: assert property (bad_ff == 3'h7 && !cs_n && rd_strobe && reg_addr == 2'h0
        |=> data_out[`ST_NOT_READY]) else $error("not ready bit clear");
    a_drq_wr_clear: assert property (!cs_n && wr_strobe && reg_addr == 2'h3 |=> !data_request)
        else $error("request kept after data write");
    a_byte_answer: assert property (disk_byte_req && write_gate |=> disk_byte_valid || !write_gate)
        else $error("byte not answered");
    a_mark_bytes: assert property (disk_byte_valid && missing_clock
        |-> disk_byte == 8'hA1 || disk_byte == 8'hC2) else $error("bad mark byte");
    a_gate_not_ready: assert property (bad_ff == 3'h7 |-> !$rose(write_gate))
        else $error("write started while not ready");
    a_end_irq: assert property (!$past(rst) && $fell(write_gate) |-> interrupt_request)
        else $error("no interrupt at end");
endmodule
bind fdc_status_format fdc_status_format_checker chk_i (.mclk, .rst, .cs_n, .rd_strobe, .wr_strobe,
    .reg_addr, .data_in, .data_out, .ready_in, .write_protect_in, .disk_byte_req, .disk_byte,
    .disk_byte_valid, .missing_clock, .write_gate, .head_load_out, .data_request, .interrupt_request);

// ==== dv/fdc_host_model.sv ====
`timescale 1ns/100ps
module fdc_host_model (
    input wire logic mclk, // Clock
    input wire logic data_request, // Byte wanted
    input wire logic interrupt_request, // Command ended
    input wire logic [7:0] data_out, // Read data
    output logic cs_n, // Select, low
    output logic rd_strobe, // Read pulse
    output logic wr_strobe, // Write pulse
    output logic [1:0] reg_addr, // Register
    output logic [7:0] data_in // Write data
);
    // Idle bus at time zero
    initial begin
        cs_n = 1'b1;
        rd_strobe = 1'b0;
        wr_strobe = 1'b0;
        reg_addr = 2'h0;
        data_in = 8'h00;
    end
    // One-cycle strobe; data inverted on release so a stale byte never looks valid
    task wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge mclk) #1;
        {cs_n, wr_strobe, reg_addr, data_in} = {1'b0, 1'b1, a, d};
        @(posedge mclk) #1;
        {cs_n, wr_strobe, data_in} = {1'b1, 1'b0, ~d};
        @(posedge mclk) #1;
    endtask
    task rd(input logic [1:0] a, output logic [7:0] d);
        @(posedge mclk) #1;
        {cs_n, rd_strobe, reg_addr} = {1'b0, 1'b1, a};
        @(posedge mclk) #1;
        {cs_n, rd_strobe} = 2'h2;
        @(posedge mclk) #1;
        d = data_out;
    endtask
    // One byte per data request, never ahead of it
    task put(input int n, input logic [7:0] b);
        repeat (n) begin
            while (!data_request) @(posedge mclk) #1;
            wr(2'h3, b);
        end
    endtask
    task track(input int sectors);
        put(80, 8'h4E); put(12, 8'h00); put(3, 8'hF6); put(1, 8'hFC);
        repeat (sectors) begin
            put(50, 8'h4E); put(12, 8'h00); put(3, 8'hF5);
            put(1, 8'hFE); put(2, 8'h00); put(2, 8'h01); put(1, 8'hF7);
            put(22, 8'h4E); put(12, 8'h00); put(3, 8'hF5); put(1, 8'hFB);
            put(256, 8'hE5); put(1, 8'hF7); put(54, 8'h4E);
        end
        while (!interrupt_request) begin
            if (data_request) wr(2'h3, 8'h4E);
            else @(posedge mclk) #1;
        end
    endtask
endmodule

// ==== dv/floppy_track_format_status_bench.sv ====
`timescale 1ns/100ps
module floppy_track_format_status_bench;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic ready_in = 1'b0, write_protect_in = 1'b1, track_zero_in = 1'b1, index_pulse_in = 1'b1;
    logic head_load_timing_in = 1'b1, density_select_n = 1'b0;
    logic record_not_found = 1'b0, deleted_mark_in = 1'b0, disk_byte_req = 1'b0, master_reset_n = 1'b1;
    logic cs_n, rd_strobe, wr_strobe, disk_byte_valid, missing_clock, write_gate, head_load_out;
    logic data_request, interrupt_request;
    logic [1:0] reg_addr;
    logic [7:0] data_in, data_out, disk_byte, s;
    logic [8:0] q[$];
    int error_cnt = 0, checks = 0, cyc = 0;
    always #5 mclk = ~mclk;
    fdc_status_format uut (.mclk, .rst, .master_reset_n, .cs_n, .rd_strobe, .wr_strobe, .reg_addr,
        .data_in, .data_out, .ready_in, .write_protect_in, .head_load_timing_in, .track_zero_in,
        .index_pulse_in, .density_select_n, .seek_error_in(1'b0), .id_crc_error_in(1'b0),
        .data_crc_error_in(1'b0), .record_not_found, .deleted_mark_in, .write_fault_in(1'b0),
        .disk_byte_req, .disk_byte, .disk_byte_valid, .missing_clock, .write_gate, .head_load_out,
        .data_request, .interrupt_request);
    fdc_host_model host (.mclk, .data_request, .interrupt_request, .data_out, .cs_n, .rd_strobe,
        .wr_strobe, .reg_addr, .data_in);
    // Serializer asks every eighth cycle while writing; records bytes; cuts off a hang
    always @(posedge mclk) begin
        cyc++;
        disk_byte_req <= #1 write_gate && (cyc % 8 == 0);
        if (disk_byte_valid) q.push_back({missing_clock, disk_byte});
        if (cyc == 40000) begin
            error_cnt++;
            complete_run();
        end
    end
    task chk(input string name, input logic [8:0] exp, input logic [8:0] got);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task idx;
        @(posedge mclk) #1 index_pulse_in = 1'b0;
        tick(20);
        index_pulse_in = 1'b1;
    endtask
    task status(input logic [7:0] mask, input logic [7:0] exp, input string name);
        host.rd(2'h0, s);
        chk(name, {1'b0, exp}, {1'b0, s & mask});
    endtask
    task complete_run;
        $display("errors %0d checks %0d", error_cnt, checks);
        if (error_cnt == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        tick(12);
        rst = 1'b0;
        tick(9);
        host.wr(2'h0, 8'hF0);
        tick(2);
        chk("irq refused", 9'h001, {8'h00, interrupt_request});
        status(8'h81, 8'h80, "not ready");
        {ready_in, write_protect_in, track_zero_in} = 3'h4;
        tick(6);
        host.wr(2'h0, 8'hD0);
        tick(4);
        status(8'hFF, 8'h44, "positioning");
        {write_protect_in, track_zero_in} = 2'h3;
        host.wr(2'h0, 8'h80);
        tick(2);
        {record_not_found, deleted_mark_in} = 2'h3;
        tick(1);
        {record_not_found, deleted_mark_in} = 2'h0;
        host.wr(2'h0, 8'hD0);
        tick(4);
        status(8'h39, 8'h30, "read sector");
        host.wr(2'h0, 8'hF0);
        tick(4);
        idx();
        tick(4);
        chk("irq lost", 9'h001, {8'h00, interrupt_request});
        status(8'h05, 8'h04, "lost data");
        host.wr(2'h0, 8'hF0);
        fork
            host.track(2);
            begin
                tick(40);
                idx();
                while (q.size() < 1000) @(posedge mclk);
                idx();
            end
        join
        tick(2);
        chk("irq end", 9'h001, {8'h00, interrupt_request});
        status(8'h19, 8'h00, "format done");
        chk("gap fill", 9'h04E, q[0]);
        chk("sync c2", 9'h1C2, q[92]);
        chk("index mark", 9'h0FC, q[95]);
        chk("sync a1", 9'h1A1, q[158]);
        chk("id mark", 9'h0FE, q[161]);
        chk("after id crc", 9'h04E, q[168]);
        chk("data mark", 9'h0FB, q[205]);
        chk("after data crc", 9'h04E, q[464]);
        master_reset_n = 1'b0;
        tick(4);
        status(8'h81, 8'h80, "master reset");
        master_reset_n = 1'b1;
        tick(4);
        status(8'h81, 8'h00, "ready again");
        complete_run();
    end
endmodule
